// [pkg/dtsh_pkg.sv]
// =====================================================
// message codes and lengths
package dtsh_pkg;
    localparam logic [7:0] CODE_GRANT  = 8'h21;
    localparam logic [7:0] CODE_REQ    = 8'h22;
    localparam logic [7:0] CODE_REDIR  = 8'h23;
    localparam logic [4:0] LEN_GRANT   = 5'h10;
    localparam logic [4:0] LEN_REQ     = 5'h0E;
    localparam logic [4:0] LEN_REDIR   = 5'h15;
    localparam int         MSG_BYTES   = 21;
    // =====================================================
    // byte positions inside a message
    localparam int         POS_CODE    = 0;
    localparam int         POS_TAG     = 2;
    localparam int         POS_RPID    = 4;
    localparam int         POS_OFF     = 4;
    localparam int         POS_CNT     = 8;
    localparam int         POS_CHAN    = 12;
    localparam int         POS_XID     = 14;
    localparam int         POS_OPATH   = 16;
    localparam int         POS_OPORT   = 20;
    localparam int         MOD8_BITS   = 3;
    localparam logic [7:0] RSVD_BYTE   = 8'h00;
    // =====================================================
    // alert and return codes (values arbitrary)
    localparam logic [7:0] ALERT_BAD_RPID   = 8'h01;
    localparam logic [7:0] ALERT_BAD_FIELD  = 8'h02;
    localparam logic [7:0] ALERT_UNEXPECTED = 8'h03;
    localparam logic [7:0] ALERT_TOO_MANY   = 8'h04;
    localparam logic [7:0] RET_BAD_FIELD    = 8'h01;
    // =====================================================
    // state encodings, gray along the usual path
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_BODY = 2'h1,
        RX_EVAL = 2'h3,
        RX_HOLD = 2'h2
    } dtsh_rx_e;
    typedef enum logic {
        TX_IDLE = 1'h0,
        TX_SEND = 1'h1
    } dtsh_tx_e;
    typedef logic [MSG_BYTES-1:0][7:0] dtsh_msg_t;
endpackage : dtsh_pkg

// [design/dtsh_handler.sv]
`timescale 1ns/1ps
`default_nettype none
// Contract
// - grant reply tag must equal the tag of the offer it answers.
// - return path mismatch raises invalid-return-path alert, then waits for another grant.
// - grant byte count breaking modulo eight raises invalid-field alert.
// - data frames use the grant channel and return or outbound path.
// - same channel grants transfer in order; different channels may overlap. The code holds a grant only on the channel taken last, until any grant done.
// - other bad fields get invalid-field response; path, unexpected, overflow get alerts.
// - data request is code 22h, 14 bytes, fixed field layout.
// - a data request stays outstanding until its last data frame arrives.
// - data request carries the originating command tag.
// - data request offset is a multiple of eight.
// - data request count is a multiple of eight except the final piece.
// - offset plus count must not exceed the transfer length.
// - receive channel allocated before request; bad fields abort via upper layer.
// - new request only if none outstanding or each has seen a frame.
// - redirect sends data from named port along named path, outstanding per redirect.
// - redirect is code 23h, 21 bytes, fixed field layout.
// - grant reply is code 21h, 16 bytes, fixed field layout.
// - an accepted grant stays outstanding until its last data frame.
module dtsh_handler #(
    parameter int MAX_OUT = 4
) (
    // clock and reset
    input  wire  logic        i_clk,
    input  wire  logic        i_reset,
    // received message bytes
    input  wire  logic        i_rx_valid,
    input  wire  logic [7:0]  i_rx_byte,
    input  wire  logic        i_rx_last,
    output logic              o_rx_ready,
    // context of the io process and its offer
    input  wire  logic [15:0] i_cmd_tag,
    input  wire  logic [31:0] i_cmd_rpid,
    input  wire  logic        i_offer_open,
    input  wire  logic [15:0] i_offer_xid,
    input  wire  logic        i_offer_final,
    // accepted grant towards the data sender
    output logic              o_grant_valid,
    input  wire  logic        i_grant_take,
    output logic [15:0]       o_grant_chan,
    output logic [31:0]       o_grant_path,
    output logic [7:0]        o_grant_port,
    output logic [31:0]       o_grant_count,
    output logic              o_grant_redirect,
    input  wire  logic        i_grant_done,
    // error reports
    output logic              o_alert_valid,
    output logic [7:0]        o_alert_code,
    output logic              o_resp_valid,
    output logic [7:0]        o_resp_code,
    // data request from the receive side
    input  wire  logic        i_req_valid,
    output logic              o_req_ready,
    input  wire  logic [31:0] i_req_offset,
    input  wire  logic [31:0] i_req_count,
    input  wire  logic [15:0] i_req_chan,
    input  wire  logic        i_req_final,
    input  wire  logic [31:0] i_xfer_len,
    output logic              o_req_reject,
    input  wire  logic        i_req_frame,
    input  wire  logic        i_req_done,
    // outgoing request message bytes
    output logic              o_tx_valid,
    output logic [7:0]        o_tx_byte,
    output logic              o_tx_last,
    input  wire  logic        i_tx_ready
);
    localparam int CW = $clog2(MAX_OUT + 1);
    localparam logic [CW-1:0] CNT_MAX = CW'(MAX_OUT);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [4:0]    IDX_ONE = 5'h01;

    // =====================================================
    // helpers
    // big-endian field pick, lowest byte index most significant
    function automatic logic [31:0] f32(input dtsh_pkg::dtsh_msg_t m,
                                        input int p);
        f32 = {m[p], m[p+1], m[p+2], m[p+3]};
    endfunction : f32

    function automatic logic [15:0] f16(input dtsh_pkg::dtsh_msg_t m,
                                        input int p);
        f16 = {m[p], m[p+1]};
    endfunction : f16

    // multiple of eight unless it carries the final byte
    function automatic logic mod8_ok(input logic [31:0] c, input logic fin);
        mod8_ok = fin || (c[dtsh_pkg::MOD8_BITS-1:0] == '0);
    endfunction : mod8_ok

    // =====================================================
    // state
    typedef struct packed {
        dtsh_pkg::dtsh_rx_e  rx;
        dtsh_pkg::dtsh_tx_e  tx;
        dtsh_pkg::dtsh_msg_t msg;
        logic [4:0]          rx_idx;
        logic [4:0]          tx_idx;
        dtsh_pkg::dtsh_msg_t txm;
        logic [15:0]         g_chan;
        logic [31:0]         g_path;
        logic [7:0]          g_port;
        logic [31:0]         g_count;
        logic                g_redir;
        logic                act;
        logic [15:0]         act_chan;
        logic [CW-1:0]       g_out;
        logic [CW-1:0]       r_out;
        logic [CW-1:0]       r_seen;
        logic                alert;
        logic [7:0]          alert_code;
        logic                resp;
        logic [7:0]          resp_code;
        logic                reject;
    } dtsh_state_s;

    dtsh_state_s st_ff;
    dtsh_state_s nxt_st;

    logic        g_take;
    logic        r_start;
    logic        r_ok;
    logic [32:0] r_end;
    logic [7:0]  code;
    logic [4:0]  len;
    logic        is_grant;
    logic        is_redir;

    // =====================================================
    // handshake terms
    assign o_rx_ready = (st_ff.rx == dtsh_pkg::RX_IDLE) ||
                        (st_ff.rx == dtsh_pkg::RX_BODY);
    // a grant on the channel taken last waits until the next grant done
    assign o_grant_valid = (st_ff.rx == dtsh_pkg::RX_HOLD) &&
                           !(st_ff.act && st_ff.act_chan == st_ff.g_chan);
    assign g_take = o_grant_valid && i_grant_take;
    // new request only when every outstanding one has seen a frame
    assign o_req_ready = (st_ff.tx == dtsh_pkg::TX_IDLE) &&
                         (st_ff.r_out < CNT_MAX) &&
                         (st_ff.r_out == '0 || st_ff.r_seen == st_ff.r_out);
    assign r_start = i_req_valid && o_req_ready;
    assign r_end = {1'b0, i_req_offset} + {1'b0, i_req_count};
    assign r_ok = (i_req_offset[dtsh_pkg::MOD8_BITS-1:0] == '0) &&
                  mod8_ok(i_req_count, i_req_final) &&
                  (r_end <= {1'b0, i_xfer_len});
    assign code = st_ff.msg[dtsh_pkg::POS_CODE];
    assign len = st_ff.rx_idx;
    // exact length only, a short or padded message is unexpected
    assign is_grant = (code == dtsh_pkg::CODE_GRANT) && (len == dtsh_pkg::LEN_GRANT);
    assign is_redir = (code == dtsh_pkg::CODE_REDIR) && (len == dtsh_pkg::LEN_REDIR);

    // =====================================================
    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.alert = 1'b0;
        nxt_st.resp = 1'b0;
        nxt_st.reject = 1'b0;
        // message receiver, bytes land at their index
        case (st_ff.rx)
            dtsh_pkg::RX_IDLE, dtsh_pkg::RX_BODY: begin
                if (i_rx_valid) begin
                    if (st_ff.rx == dtsh_pkg::RX_IDLE) begin
                        nxt_st.msg = '0;
                        nxt_st.msg[0] = i_rx_byte;
                        nxt_st.rx_idx = IDX_ONE;
                    end else begin
                        if (st_ff.rx_idx < 5'(dtsh_pkg::MSG_BYTES)) begin
                            nxt_st.msg[st_ff.rx_idx] = i_rx_byte;
                        end
                        if (st_ff.rx_idx != '1) begin
                            nxt_st.rx_idx = st_ff.rx_idx + IDX_ONE;
                        end
                    end
                    nxt_st.rx = i_rx_last ? dtsh_pkg::RX_EVAL : dtsh_pkg::RX_BODY;
                end
            end
            dtsh_pkg::RX_EVAL: begin
                nxt_st.rx = dtsh_pkg::RX_IDLE;
                // priority: shape, path, modulo, fields, capacity
                if (!(is_grant || is_redir) || !i_offer_open) begin
                    nxt_st.alert = 1'b1;
                    nxt_st.alert_code = dtsh_pkg::ALERT_UNEXPECTED;
                end else if (f32(st_ff.msg, dtsh_pkg::POS_RPID) != i_cmd_rpid) begin
                    // io process lives on; a later grant is still taken
                    nxt_st.alert = 1'b1;
                    nxt_st.alert_code = dtsh_pkg::ALERT_BAD_RPID;
                end else if (!mod8_ok(f32(st_ff.msg, dtsh_pkg::POS_CNT),
                                      i_offer_final)) begin
                    nxt_st.alert = 1'b1;
                    nxt_st.alert_code = dtsh_pkg::ALERT_BAD_FIELD;
                end else if (f16(st_ff.msg, dtsh_pkg::POS_TAG) != i_cmd_tag ||
                             f16(st_ff.msg, dtsh_pkg::POS_XID) != i_offer_xid) begin
                    nxt_st.resp = 1'b1;
                    nxt_st.resp_code = dtsh_pkg::RET_BAD_FIELD;
                end else if (st_ff.g_out >= CNT_MAX) begin
                    nxt_st.alert = 1'b1;
                    nxt_st.alert_code = dtsh_pkg::ALERT_TOO_MANY;
                end else begin
                    // frame address: channel plus return or outbound path
                    nxt_st.rx = dtsh_pkg::RX_HOLD;
                    nxt_st.g_chan = f16(st_ff.msg, dtsh_pkg::POS_CHAN);
                    nxt_st.g_count = f32(st_ff.msg, dtsh_pkg::POS_CNT);
                    nxt_st.g_redir = is_redir;
                    nxt_st.g_path = is_redir ? f32(st_ff.msg, dtsh_pkg::POS_OPATH)
                                             : f32(st_ff.msg, dtsh_pkg::POS_RPID);
                    nxt_st.g_port = is_redir ? st_ff.msg[dtsh_pkg::POS_OPORT]
                                             : dtsh_pkg::RSVD_BYTE;
                end
            end
            dtsh_pkg::RX_HOLD: begin
                if (g_take) begin
                    nxt_st.rx = dtsh_pkg::RX_IDLE;
                end
            end
            default: begin
                nxt_st.rx = dtsh_pkg::RX_IDLE;
            end
        endcase
        // grant accounting, taken until its last frame
        if (g_take && !i_grant_done) begin
            nxt_st.g_out = st_ff.g_out + CNT_ONE;
        end else if (!g_take && i_grant_done && st_ff.g_out != '0) begin
            nxt_st.g_out = st_ff.g_out - CNT_ONE;
        end
        // one tracked transfer, on the channel taken last; done before a new take
        if (i_grant_done) begin
            nxt_st.act = 1'b0;
        end
        if (g_take) begin
            nxt_st.act = 1'b1;
            nxt_st.act_chan = st_ff.g_chan;
        end
        // request sender
        case (st_ff.tx)
            dtsh_pkg::TX_IDLE: begin
                if (r_start && !r_ok) begin
                    nxt_st.reject = 1'b1;
                end else if (r_start) begin
                    nxt_st.tx = dtsh_pkg::TX_SEND;
                    nxt_st.tx_idx = '0;
                    nxt_st.txm = '0;
                    nxt_st.txm[dtsh_pkg::POS_CODE] = dtsh_pkg::CODE_REQ;
                    {nxt_st.txm[dtsh_pkg::POS_TAG],
                     nxt_st.txm[dtsh_pkg::POS_TAG+1]} = i_cmd_tag;
                    {nxt_st.txm[dtsh_pkg::POS_OFF], nxt_st.txm[dtsh_pkg::POS_OFF+1],
                     nxt_st.txm[dtsh_pkg::POS_OFF+2],
                     nxt_st.txm[dtsh_pkg::POS_OFF+3]} = i_req_offset;
                    {nxt_st.txm[dtsh_pkg::POS_CNT], nxt_st.txm[dtsh_pkg::POS_CNT+1],
                     nxt_st.txm[dtsh_pkg::POS_CNT+2],
                     nxt_st.txm[dtsh_pkg::POS_CNT+3]} = i_req_count;
                    {nxt_st.txm[dtsh_pkg::POS_CHAN],
                     nxt_st.txm[dtsh_pkg::POS_CHAN+1]} = i_req_chan;
                end
            end
            dtsh_pkg::TX_SEND: begin
                if (i_tx_ready) begin
                    // shift so the head byte always comes from a flop
                    nxt_st.txm = {dtsh_pkg::RSVD_BYTE,
                                  st_ff.txm[dtsh_pkg::MSG_BYTES-1:1]};
                    nxt_st.tx_idx = st_ff.tx_idx + IDX_ONE;
                    if (st_ff.tx_idx == dtsh_pkg::LEN_REQ - IDX_ONE) begin
                        nxt_st.tx = dtsh_pkg::TX_IDLE;
                    end
                end
            end
            default: begin
                nxt_st.tx = dtsh_pkg::TX_IDLE;
            end
        endcase
        // outstanding from send until last frame; every frame adds one to seen
        nxt_st.r_out = st_ff.r_out + CW'(r_start && r_ok) - CW'(i_req_done);
        nxt_st.r_seen = st_ff.r_seen + CW'(i_req_frame) - CW'(i_req_done);
    end

    // =====================================================
    // register
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =====================================================
    // outputs
    assign o_grant_chan     = st_ff.g_chan;
    assign o_grant_path     = st_ff.g_path;
    assign o_grant_port     = st_ff.g_port;
    assign o_grant_count    = st_ff.g_count;
    assign o_grant_redirect = st_ff.g_redir;
    assign o_alert_valid    = st_ff.alert;
    assign o_alert_code     = st_ff.alert_code;
    assign o_resp_valid     = st_ff.resp;
    assign o_resp_code      = st_ff.resp_code;
    assign o_req_reject     = st_ff.reject;
    assign o_tx_valid       = (st_ff.tx == dtsh_pkg::TX_SEND);
    assign o_tx_byte        = st_ff.txm[dtsh_pkg::POS_CODE];
    assign o_tx_last        = o_tx_valid &&
                              (st_ff.tx_idx == dtsh_pkg::LEN_REQ - IDX_ONE);
endmodule : dtsh_handler
`default_nettype wire

// [verif/dtsh_peer.sv]
`timescale 1ns/1ps
`default_nettype none
// ========
// far node: takes request bytes, answers with data frames
module dtsh_peer (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset,
    // request byte stream
    input  wire logic i_stall,
    input  wire logic i_tx_valid,
    input  wire logic i_tx_last,
    output logic      o_tx_ready,
    // data frame events
    output logic      o_frame,
    output logic      o_done
);
    logic [3:0] wait_ff;
    // sink may stall on any byte, so the sender must hold it
    assign o_tx_ready = !i_stall;
    // frames start a few cycles after the whole request arrived
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) wait_ff <= 4'h0;
        else if (i_tx_valid && i_tx_last && o_tx_ready) wait_ff <= 4'h1;
        else if (wait_ff != 4'h0) wait_ff <= wait_ff + 4'h1;
    end
    // one request per frame stream, same channel finished in order
    assign o_frame = (wait_ff == 4'h4);
    assign o_done  = (wait_ff == 4'h9);
endmodule : dtsh_peer
`default_nettype wire

// [verif/dtsh_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ========
// port checker of the handler
module dtsh_chk (
    // message side
    input wire logic        i_clk, i_reset, i_rx_valid, i_rx_last, o_rx_ready, i_offer_open,
    input wire logic        o_grant_valid, i_grant_take, o_alert_valid,
    input wire logic [15:0] o_grant_chan, i_cmd_tag,
    input wire logic [31:0] o_grant_count,
    input wire logic [7:0]  o_alert_code, o_tx_byte,
    // request side
    input wire logic        i_req_valid, o_req_ready, i_req_final, o_req_reject,
    input wire logic        o_tx_valid, o_tx_last, i_tx_ready,
    input wire logic [31:0] i_req_offset, i_req_count, i_xfer_len
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic [3:0] tx_idx_ff;
    logic       fields_ok;
    // byte position on the request wire
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) tx_idx_ff <= 4'h0;
        else if (o_tx_valid && i_tx_ready) tx_idx_ff <= o_tx_last ? 4'h0 : tx_idx_ff + 4'h1;
    end
    // widened sum so a wrap cannot pass the length check
    assign fields_ok = i_req_offset[2:0] == 3'h0 && (i_req_final || i_req_count[2:0] == 3'h0)
        && ({1'b0, i_req_offset} + {1'b0, i_req_count} <= {1'b0, i_xfer_len});
    sequence s_req_take; i_req_valid && o_req_ready; endsequence
    sequence s_rx_end; i_rx_valid && o_rx_ready && i_rx_last; endsequence
    a_req_start: assert property (s_req_take ##0 fields_ok |=> o_tx_valid && o_tx_byte == 8'h22)
        else $error("request message did not start");
    a_req_refuse: assert property (s_req_take ##0 !fields_ok |=> o_req_reject && !o_tx_valid)
        else $error("bad request not refused");
    a_req_busy: assert property (s_req_take ##0 fields_ok |=> !o_req_ready [*8])
        else $error("request taken while one outstanding");
    a_req_gate: assert property (o_tx_valid |-> !o_req_ready)
        else $error("request ready while sending");
    a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte))
        else $error("request byte dropped before taken");
    a_tx_length: assert property (o_tx_valid && o_tx_last |-> tx_idx_ff == 4'hD)
        else $error("request message length wrong");
    a_tx_reserved: assert property (o_tx_valid && tx_idx_ff == 4'h1 |-> o_tx_byte == 8'h00)
        else $error("reserved byte not zero");
    a_tx_tag: assert property (o_tx_valid && tx_idx_ff == 4'h2 |-> o_tx_byte == i_cmd_tag[15:8])
        else $error("request tag byte wrong");
    a_grant_unexp: assert property (s_rx_end ##0 !i_offer_open |=> ##1
        o_alert_valid && o_alert_code == dtsh_pkg::ALERT_UNEXPECTED)
        else $error("grant without offer not alerted");
    a_grant_stand: assert property (o_grant_valid && !i_grant_take |=>
        o_grant_valid && $stable(o_grant_chan) && $stable(o_grant_count))
        else $error("grant changed before taken");
endmodule : dtsh_chk
bind dtsh_handler dtsh_chk i_chk (.i_clk, .i_reset, .i_rx_valid, .i_rx_last, .o_rx_ready,
    .i_offer_open, .o_grant_valid, .i_grant_take, .o_alert_valid, .o_grant_chan, .i_cmd_tag,
    .o_grant_count, .o_alert_code, .o_tx_byte, .i_req_valid, .o_req_ready, .i_req_final,
    .o_req_reject, .o_tx_valid, .o_tx_last, .i_tx_ready, .i_req_offset, .i_req_count,
    .i_xfer_len);
`default_nettype wire

// [verif/tb_data_transfer_sms_handler.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_data_transfer_sms_handler;
    // ========
    // signals
    logic        i_clk = 1'b0, i_reset = 1'b1, i_rx_valid = 1'b0, i_rx_last = 1'b0;
    logic        i_offer_open = 1'b0, i_offer_final = 1'b0, i_grant_take = 1'b0;
    logic        i_grant_done = 1'b0, i_req_valid = 1'b0, i_req_final = 1'b0, stall = 1'b0;
    logic [7:0]  i_rx_byte = 8'h00;
    logic [15:0] i_cmd_tag = 16'h0, i_offer_xid = 16'h0, i_req_chan = 16'h0, tg, xd, ch;
    logic [31:0] i_cmd_rpid = 32'h0, i_req_offset = 32'h0, i_req_count = 32'h0;
    logic [31:0] i_xfer_len = 32'h0, rp, op, cnt;
    logic        o_rx_ready, o_grant_valid, o_grant_redirect, o_alert_valid, o_resp_valid;
    logic        o_req_ready, o_req_reject, o_tx_valid, o_tx_last, i_tx_ready;
    logic        i_req_frame, i_req_done;
    logic [7:0]  o_grant_port, o_alert_code, o_resp_code, o_tx_byte;
    logic [15:0] o_grant_chan;
    logic [31:0] o_grant_path, o_grant_count;
    logic [92:0] exp_q[$];
    int          n_errors = 0;
    int          comparisons = 0;
    integer      seed = 32'hE2B2C4D1;
    dtsh_handler #(.MAX_OUT(2)) i_dut (.i_clk, .i_reset, .i_rx_valid, .i_rx_byte, .i_rx_last,
        .o_rx_ready, .i_cmd_tag, .i_cmd_rpid, .i_offer_open, .i_offer_xid, .i_offer_final,
        .o_grant_valid, .i_grant_take, .o_grant_chan, .o_grant_path, .o_grant_port,
        .o_grant_count, .o_grant_redirect, .i_grant_done, .o_alert_valid, .o_alert_code,
        .o_resp_valid, .o_resp_code, .i_req_valid, .o_req_ready, .i_req_offset, .i_req_count,
        .i_req_chan, .i_req_final, .i_xfer_len, .o_req_reject, .i_req_frame, .i_req_done,
        .o_tx_valid, .o_tx_byte, .o_tx_last, .i_tx_ready);
    dtsh_peer i_peer (.i_clk, .i_reset, .i_stall(stall), .i_tx_valid(o_tx_valid),
        .i_tx_last(o_tx_last), .o_tx_ready(i_tx_ready), .o_frame(i_req_frame),
        .o_done(i_req_done));
    // ========
    // clock, random stall, consumer that takes every grant
    always #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        stall <= ($random(seed) & 32'h3) == 32'h0;
        i_grant_take <= o_grant_valid && !i_grant_take;
    end
    task automatic results();
        if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic cmp(input logic [92:0] e, input logic [92:0] g);
        comparisons++;
        if (e !== g) begin
            n_errors++;
            $display("ERROR at %0t: expected %h got %h", $time, e, g);
        end
    endtask : cmp
    function automatic logic [92:0] ax(input logic [3:0] k, input logic [7:0] c);
        return {k, 81'h0, c};
    endfunction : ax
    // reply uses the return path, redirect the outbound path and port
    function automatic logic [92:0] gx(input logic rd, input logic [31:0] n, input logic [15:0] c);
        return {4'h5, rd, rd ? 8'h5A : 8'h00, rd ? op : rp, c, n};
    endfunction : gx
    // ========
    // watcher: every result pops the oldest note
    always @(negedge i_clk) begin
        logic [92:0] e;
        e = '1;
        if (o_alert_valid === 1'b1 || o_resp_valid === 1'b1 || o_req_reject === 1'b1 ||
            (o_tx_valid === 1'b1 && i_tx_ready) || (o_grant_valid === 1'b1 && i_grant_take)) begin
            if (exp_q.size() != 0) e = exp_q.pop_front();
            if (o_alert_valid === 1'b1) cmp(e, ax(4'h1, o_alert_code));
            else if (o_resp_valid === 1'b1) cmp(e, ax(4'h2, o_resp_code));
            else if (o_req_reject === 1'b1) cmp(e, ax(4'h3, 8'h00));
            else if (o_tx_valid === 1'b1) cmp(e, ax(4'h4, o_tx_byte));
            else cmp(e, {4'h5, o_grant_redirect, o_grant_port, o_grant_path, o_grant_chan,
                o_grant_count});
        end
    end
    // ========
    // drivers
    task automatic msg(input logic [92:0] e, input logic [7:0] code, input logic [31:0] rpid,
                       input logic [31:0] n, input logic [15:0] c, input logic [15:0] tag,
                       input logic [15:0] xid);
        logic [167:0] m;
        int           len;
        exp_q.push_back(e);
        len = (code == dtsh_pkg::CODE_REDIR) ? 21 : 16;
        m = {code, 8'h00, tag, rpid, n, c, xid, op, 8'h5A};
        for (int k = 0; k < len; k++) begin
            i_rx_valid <= 1'b1;
            i_rx_byte <= m[167-8*k -: 8];
            i_rx_last <= (k == len - 1);
            do @(posedge i_clk); while (o_rx_ready !== 1'b1);
        end
        i_rx_valid <= 1'b0;
        i_rx_last <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask : msg
    task automatic gr(input logic [92:0] e, input logic [31:0] rpid, input logic [31:0] n,
                      input logic [15:0] c, input logic [15:0] tag, input logic [15:0] xid);
        msg(e, dtsh_pkg::CODE_GRANT, rpid, n, c, tag, xid);
    endtask : gr
    task automatic done1();
        i_grant_done <= 1'b1;
        @(posedge i_clk);
        i_grant_done <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask : done1
    task automatic req(input logic [31:0] off, input logic [31:0] n, input logic fin,
                       input logic ok, input logic [15:0] c);
        logic [111:0] m;
        m = {dtsh_pkg::CODE_REQ, 8'h00, tg, off, n, c};
        if (ok) for (int k = 0; k < 14; k++) exp_q.push_back(ax(4'h4, m[111-8*k -: 8]));
        else exp_q.push_back(ax(4'h3, 8'h00));
        i_req_valid <= 1'b1;
        i_req_offset <= off;
        i_req_count <= n;
        i_req_final <= fin;
        i_req_chan <= c;
        do @(posedge i_clk); while (o_req_ready !== 1'b1);
        i_req_valid <= 1'b0;
        repeat (24) @(posedge i_clk);
    endtask : req
    // ========
    // scenarios
    initial begin
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        rp = $random(seed);
        op = $random(seed);
        tg = $random(seed);
        xd = $random(seed);
        i_cmd_rpid <= rp;
        i_cmd_tag <= tg;
        i_offer_xid <= xd;
        i_xfer_len <= 32'h100;
        @(posedge i_clk);
        gr(ax(4'h1, dtsh_pkg::ALERT_UNEXPECTED), rp, 32'h40, 16'h11, tg, xd);
        i_offer_open <= 1'b1;
        gr(gx(1'b0, 32'h40, 16'h11), rp, 32'h40, 16'h11, tg, xd);
        done1();
        msg(gx(1'b1, 32'h80, 16'h22), dtsh_pkg::CODE_REDIR, rp, 32'h80, 16'h22, tg, xd);
        done1();
        gr(ax(4'h1, dtsh_pkg::ALERT_BAD_RPID), ~rp, 32'h40, 16'h11, tg, xd);
        gr(ax(4'h1, dtsh_pkg::ALERT_BAD_FIELD), rp, 32'h43, 16'h11, tg, xd);
        gr(ax(4'h2, dtsh_pkg::RET_BAD_FIELD), rp, 32'h40, 16'h11, ~tg, xd);
        gr(ax(4'h2, dtsh_pkg::RET_BAD_FIELD), rp, 32'h40, 16'h11, tg, ~xd);
        i_offer_final <= 1'b1;
        gr(gx(1'b0, 32'h43, 16'h11), rp, 32'h43, 16'h11, tg, xd);
        i_offer_final <= 1'b0;
        done1();
        // partial grants of random size, one after another
        repeat (4) begin
            cnt = $random(seed) & 32'h0000FFF8;
            ch = $random(seed);
            gr(gx(1'b0, cnt, ch), rp, cnt, ch, tg, xd);
            done1();
        end
        gr(gx(1'b0, 32'h08, 16'h33), rp, 32'h08, 16'h33, tg, xd);
        gr(gx(1'b0, 32'h10, 16'h33), rp, 32'h10, 16'h33, tg, xd);
        repeat (8) @(posedge i_clk);
        cmp(93'h0, {92'h0, o_grant_valid});
        done1();
        done1();
        gr(gx(1'b0, 32'h08, 16'h44), rp, 32'h08, 16'h44, tg, xd);
        gr(gx(1'b0, 32'h08, 16'h55), rp, 32'h08, 16'h55, tg, xd);
        gr(ax(4'h1, dtsh_pkg::ALERT_TOO_MANY), rp, 32'h08, 16'h66, tg, xd);
        done1();
        done1();
        req(32'h08, 32'h20, 1'b0, 1'b1, 16'h000A);
        req(32'h28, 32'h18, 1'b0, 1'b1, 16'h000A);
        req(32'h04, 32'h20, 1'b0, 1'b0, 16'h000B);
        req(32'h40, 32'h1C, 1'b0, 1'b0, 16'h000B);
        req(32'hE0, 32'h1C, 1'b1, 1'b1, 16'h000B);
        req(32'hF8, 32'h10, 1'b0, 1'b0, 16'h000C);
        req(32'hF0, 32'h10, 1'b0, 1'b1, 16'h000C);
        repeat (60) @(posedge i_clk);
        cmp(93'h0, 93'(exp_q.size()));
        results();
    end
    // hang guard, far beyond the length of the scenarios
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        results();
    end
endmodule : tb_data_transfer_sms_handler
`default_nettype wire
